// [verilog/cps_defs.svh]
// Constants for the configuration port state machine: port decode,
// keys, configuration register indices, reset values and timing.
// Assumes an 8-bit I/O data path and a 16-bit I/O address.
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

// Configuration port base addresses chosen by the strap.
`define CPS_BASE_STRAP_LOW 16'h002E
`define CPS_BASE_STRAP_HIGH 16'h004E
`define CPS_DATA_PORT_STEP 16'h0001

// Keys written to the configuration port.
`define CPS_KEY_ENTER 8'h55
`define CPS_KEY_EXIT 8'hAA

// Global configuration register indices.
`define CPS_IDX_CTRL 8'h02
`define CPS_IDX_LDN 8'h07
`define CPS_IDX_DEV_ID 8'h20
`define CPS_IDX_DEV_REV 8'h21
`define CPS_IDX_PWR_CTRL 8'h22
`define CPS_IDX_PWR_MGMT 8'h23
`define CPS_IDX_OSC 8'h24
`define CPS_IDX_BASE_LOW 8'h26
`define CPS_IDX_BASE_HIGH 8'h27
`define CPS_IDX_FIRST_LD 8'h30

// Logical device register indices.
`define CPS_IDX_ACTIVATE 8'h30
`define CPS_IDX_IO_HIGH 8'h60
`define CPS_IDX_IO_LOW 8'h61
`define CPS_IDX_IRQ 8'h70
`define CPS_IDX_DMA 8'h74
`define CPS_IDX_MODE 8'hF0

// Field positions.
`define CPS_CTRL_SOFT_RESET_BIT 0
`define CPS_ACTIVATE_BIT 0

// Number of logical device slots and width of their index.
`define CPS_NUM_LD 16
`define CPS_LD_BITS 4

// Reset values.
`define CPS_RST_ZERO 8'h00
`define CPS_RST_OSC 8'h44
`define CPS_RST_BASE_HIGH 8'h00

// Host accesses are held off after supply power-on.
`define CPS_POR_BLOCK_NS 500000
`define CPS_CLK_PERIOD_NS 40
`define CPS_POR_BLOCK_CYCLES (`CPS_POR_BLOCK_NS / `CPS_CLK_PERIOD_NS)
`define CPS_POR_CNT_BITS 14

`endif

// [verilog/cps_pkg.sv]
// Types shared by the configuration port state machine.
// Assumes nothing of its surroundings.
`default_nettype none

package cps_pkg;

   // Two access states, one-hot.
   typedef enum logic [1:0]
   {
      CPS_RUN = 2'b01,
      CPS_CFG = 2'b10
   } cps_state_type;

endpackage : cps_pkg

`default_nettype wire

// [verilog/cps_config_port.sv]
// Configuration port state machine with its global and per logical
// device configuration registers, reached through an index/data pair.
// Assumes one-cycle I/O read and write strobes synchronous to clk_sys;
// rst is the supply power-on reset, host_bus_reset_n the bus reset.
//
// Overview of operation
// - After either reset the block is in Run and every logical device is off.
// - Strap sampled at bus reset falling edge or at power-on reset.
// - Strap low puts the configuration port at 0x2E, high at 0x4E.
// - Software may move the port by writing the low and high base bytes.
// - Key 0x55 on the configuration port enters Configuration state.
// - Byte 0xAA on the configuration port returns to Run.
// - Index and data ports respond only in Configuration state.
// - Index port sits at the configuration port; data port one above it.
// - Index 0x07 then data selects and holds the current logical device.
// - Later data accesses reach the indexed register of that device.
// - Global registers need no logical device selection.
// - Only Run and Configuration exist; Run accepts the entry key except in power-on hold-off, bus reset or with ce low.
// - All host accesses are blocked for 500 us after power-on reset.
// - Writing one to control bit 0 soft-resets the sensitive registers.
`timescale 1ns/1ns
`default_nettype none
`include "cps_defs.svh"

module cps_config_port
   import cps_pkg::*;
#(
   parameter int POR_BLOCK_CYCLES = `CPS_POR_BLOCK_CYCLES,
   // Identity values below are arbitrary.
   parameter logic [7:0] DEVICE_ID = 8'hA5,
   parameter logic [7:0] DEVICE_REV = 8'h01
)
(
   // Clock, reset and freeze.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   // Bus reset and strap.
   input wire logic host_bus_reset_n,
   input wire logic addr_strap,
   // Host I/O cycles.
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rd_hit,
   // Configuration state seen by the logical devices.
   output logic config_mode,
   output logic [`CPS_NUM_LD-1:0] ld_active,
   output logic [7:0] power_ctrl,
   output logic [7:0] power_mgmt,
   output logic [7:0] osc_ctrl
);

   ////////////////////////////////////////////////////////////////////////
   // State.
   cps_state_type state;
   logic [7:0] index_reg;
   logic [7:0] ldn;
   logic [7:0] port_base_low;
   logic [7:0] port_base_high;
   logic bus_reset_prev;
   logic strap_pending;
   logic [`CPS_POR_CNT_BITS-1:0] por_count;
   logic [7:0] ld_io_high [`CPS_NUM_LD];
   logic [7:0] ld_io_low [`CPS_NUM_LD];
   logic [7:0] ld_irq [`CPS_NUM_LD];
   logic [7:0] ld_dma [`CPS_NUM_LD];
   logic [7:0] ld_mode [`CPS_NUM_LD];

   ////////////////////////////////////////////////////////////////////////
   // Decode.
   wire logic hard_reset = !host_bus_reset_n;
   wire logic strap_take = strap_pending
      || (bus_reset_prev && !host_bus_reset_n);
   wire logic [7:0] strap_base = addr_strap
      ? 8'(`CPS_BASE_STRAP_HIGH) : 8'(`CPS_BASE_STRAP_LOW);
   wire logic blocked = por_count != '0;
   wire logic [15:0] cfg_addr = {port_base_high, port_base_low};
   wire logic [15:0] data_addr = cfg_addr + `CPS_DATA_PORT_STEP;
   wire logic live = ce && !blocked && !hard_reset;
   wire logic in_cfg = state == CPS_CFG;
   wire logic at_cfg = io_addr == cfg_addr;
   wire logic at_data = io_addr == data_addr;
   wire logic key_enter = live && !in_cfg && io_wr && at_cfg
      && io_wdata == `CPS_KEY_ENTER;
   wire logic key_exit = live && in_cfg && io_wr && at_cfg
      && io_wdata == `CPS_KEY_EXIT;
   wire logic index_wr = live && in_cfg && io_wr && at_cfg
      && !key_exit;
   wire logic data_wr = live && in_cfg && io_wr && at_data;
   wire logic cfg_rd = live && in_cfg && io_rd && (at_cfg || at_data);
   wire logic global_sel = index_reg < `CPS_IDX_FIRST_LD;
   wire logic ld_valid = ldn < 8'(`CPS_NUM_LD);
   wire logic [`CPS_LD_BITS-1:0] ld_idx = ldn[`CPS_LD_BITS-1:0];
   wire logic ld_wr = data_wr && !global_sel && ld_valid;
   wire logic gwr_ldn = data_wr && index_reg == `CPS_IDX_LDN;
   wire logic gwr_ctrl = data_wr && index_reg == `CPS_IDX_CTRL;
   wire logic soft_reset = gwr_ctrl
      && io_wdata[`CPS_CTRL_SOFT_RESET_BIT];
   wire logic gwr_pwr_ctrl = data_wr && index_reg == `CPS_IDX_PWR_CTRL;
   wire logic gwr_pwr_mgmt = data_wr && index_reg == `CPS_IDX_PWR_MGMT;
   wire logic gwr_osc = data_wr && index_reg == `CPS_IDX_OSC;
   wire logic gwr_base_low = data_wr && index_reg == `CPS_IDX_BASE_LOW;
   wire logic gwr_base_high = data_wr && index_reg == `CPS_IDX_BASE_HIGH;
   wire cps_state_type next_state = key_enter ? CPS_CFG
      : (key_exit ? CPS_RUN : state);

   ////////////////////////////////////////////////////////////////////////
   // Read data selection.

   logic [7:0] ld_rdata;
   logic [7:0] glob_rdata;
   wire logic [7:0] next_rdata = at_cfg ? index_reg
      : (global_sel ? glob_rdata : (ld_valid ? ld_rdata : `CPS_RST_ZERO));

   always_comb
   begin
      unique case (index_reg)
         `CPS_IDX_LDN: glob_rdata = ldn;
         `CPS_IDX_DEV_ID: glob_rdata = DEVICE_ID;
         `CPS_IDX_DEV_REV: glob_rdata = DEVICE_REV;
         `CPS_IDX_PWR_CTRL: glob_rdata = power_ctrl;
         `CPS_IDX_PWR_MGMT: glob_rdata = power_mgmt;
         `CPS_IDX_OSC: glob_rdata = osc_ctrl;
         `CPS_IDX_BASE_LOW: glob_rdata = port_base_low;
         `CPS_IDX_BASE_HIGH: glob_rdata = port_base_high;
         default: glob_rdata = `CPS_RST_ZERO;
      endcase
   end

   always_comb
   begin
      unique case (index_reg)
         `CPS_IDX_ACTIVATE: ld_rdata = {7'h00, ld_active[ld_idx]};
         `CPS_IDX_IO_HIGH: ld_rdata = ld_io_high[ld_idx];
         `CPS_IDX_IO_LOW: ld_rdata = ld_io_low[ld_idx];
         `CPS_IDX_IRQ: ld_rdata = ld_irq[ld_idx];
         `CPS_IDX_DMA: ld_rdata = ld_dma[ld_idx];
         `CPS_IDX_MODE: ld_rdata = ld_mode[ld_idx];
         default: ld_rdata = `CPS_RST_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Power-on hold-off and strap capture.

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         por_count <= `CPS_POR_CNT_BITS'(POR_BLOCK_CYCLES);
         strap_pending <= 1'b1;
         bus_reset_prev <= 1'b1;
         port_base_low <= 8'(`CPS_BASE_STRAP_LOW);
         port_base_high <= `CPS_RST_BASE_HIGH;
      end
      else if (ce)
      begin
         if (blocked)
            por_count <= por_count - 1'b1;
         strap_pending <= 1'b0;
         bus_reset_prev <= host_bus_reset_n;
         // The base comes from the strap, software may move it later.
         if (strap_take)
         begin
            port_base_low <= strap_base;
            port_base_high <= `CPS_RST_BASE_HIGH;
         end
         else if (gwr_base_low)
            port_base_low <= io_wdata;
         else if (gwr_base_high)
            port_base_high <= io_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access state, index, logical device number and global registers.

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state <= CPS_RUN;
         config_mode <= 1'b0;
         index_reg <= `CPS_RST_ZERO;
         ldn <= `CPS_RST_ZERO;
         power_ctrl <= `CPS_RST_ZERO;
         power_mgmt <= `CPS_RST_ZERO;
         osc_ctrl <= `CPS_RST_OSC;
      end
      else if (ce)
      begin
         if (hard_reset)
         begin
            state <= CPS_RUN;
            config_mode <= 1'b0;
            index_reg <= `CPS_RST_ZERO;
            ldn <= `CPS_RST_ZERO;
            power_ctrl <= `CPS_RST_ZERO;
            power_mgmt <= `CPS_RST_ZERO;
            osc_ctrl <= `CPS_RST_OSC;
         end
         else
         begin
            state <= next_state;
            config_mode <= next_state == CPS_CFG;
            if (index_wr)
               index_reg <= io_wdata;
            if (soft_reset)
            begin
               ldn <= `CPS_RST_ZERO;
               power_ctrl <= `CPS_RST_ZERO;
            end
            else
            begin
               if (gwr_ldn)
                  ldn <= io_wdata;
               if (gwr_pwr_ctrl)
                  power_ctrl <= io_wdata;
            end
            if (gwr_pwr_mgmt)
               power_mgmt <= io_wdata;
            if (gwr_osc)
               osc_ctrl <= io_wdata;
         end
      end
   end

   // Read answers are registered one cycle after the strobe.
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         io_rdata <= `CPS_RST_ZERO;
         io_rd_hit <= 1'b0;
      end
      else if (ce)
      begin
         io_rd_hit <= cfg_rd;
         io_rdata <= cfg_rd ? next_rdata : `CPS_RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Logical device register slots.

   for (genvar i = 0; i < `CPS_NUM_LD; i++)
   begin : g_ld
      wire logic sel = ld_wr && ld_idx == `CPS_LD_BITS'(i);
      always_ff @(posedge clk_sys or posedge rst)
      begin
         if (rst)
         begin
            ld_active[i] <= 1'b0;
            ld_io_high[i] <= `CPS_RST_ZERO;
            ld_io_low[i] <= `CPS_RST_ZERO;
            ld_irq[i] <= `CPS_RST_ZERO;
            ld_dma[i] <= `CPS_RST_ZERO;
            ld_mode[i] <= `CPS_RST_ZERO;
         end
         else if (ce)
         begin
            if (hard_reset || soft_reset)
            begin
               ld_active[i] <= 1'b0;
               ld_io_high[i] <= `CPS_RST_ZERO;
               ld_io_low[i] <= `CPS_RST_ZERO;
               ld_irq[i] <= `CPS_RST_ZERO;
               ld_dma[i] <= `CPS_RST_ZERO;
               if (hard_reset)
                  ld_mode[i] <= `CPS_RST_ZERO;
            end
            else if (sel)
            begin
               unique case (index_reg)
                  `CPS_IDX_ACTIVATE:
                     ld_active[i] <= io_wdata[`CPS_ACTIVATE_BIT];
                  `CPS_IDX_IO_HIGH: ld_io_high[i] <= io_wdata;
                  `CPS_IDX_IO_LOW: ld_io_low[i] <= io_wdata;
                  `CPS_IDX_IRQ: ld_irq[i] <= io_wdata;
                  `CPS_IDX_DMA: ld_dma[i] <= io_wdata;
                  `CPS_IDX_MODE: ld_mode[i] <= io_wdata;
                  default: ;
               endcase
            end
         end
      end
   end

endmodule : cps_config_port

`default_nettype wire

// [verif/cps_config_port_checker.sv]
// Assertions on the ports of the configuration port state machine.
// Assumes clk_sys rising edge and the active high reset rst.
`timescale 1ns/1ns
`default_nettype none
module cps_config_port_checker
#(
   parameter int POR_BLOCK_CYCLES = 4
)
(
   // Clock and resets.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic host_bus_reset_n,
   // Host cycles.
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rd_hit,
   // State.
   input wire logic config_mode,
   input wire logic [15:0] ld_active,
   input wire logic [7:0] power_mgmt,
   input wire logic [7:0] osc_ctrl
);
   int por_cnt;
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         por_cnt <= 0;
      else if (ce && por_cnt < POR_BLOCK_CYCLES)
         por_cnt <= por_cnt + 1;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   chk_por_hold: assert property (por_cnt < POR_BLOCK_CYCLES
      |=> !io_rd_hit && !config_mode) else $error("access in hold");
   chk_cfg_stays: assert property (config_mode && host_bus_reset_n
      && !(io_wr && io_wdata == 8'hAA) |=> config_mode)
      else $error("left configuration");
   chk_run_stays: assert property (!config_mode
      && !(io_wr && io_wdata == 8'h55) |=> !config_mode)
      else $error("left run");
   chk_exit_cause: assert property ($fell(config_mode) |->
      !$past(host_bus_reset_n) || ($past(io_wr) && $past(io_wdata) == 8'hAA))
      else $error("exit without key");
   chk_hard_reset: assert property (!host_bus_reset_n && ce
      |=> !config_mode && ld_active == 16'h0000)
      else $error("bus reset ignored");
   chk_hit_cause: assert property (io_rd_hit |->
      $past(io_rd) && $past(config_mode) && $past(ce))
      else $error("stray hit");
   chk_idle_rdata: assert property (!io_rd_hit |-> io_rdata == 8'h00)
      else $error("read data without hit");
   chk_run_regs: assert property (!config_mode && host_bus_reset_n
      |=> $stable(ld_active) && $stable(power_mgmt) && $stable(osc_ctrl))
      else $error("register changed in run");
   cover property ($rose(config_mode));
   cover property (io_rd_hit);
   cover property ($fell(ld_active[3]));
endmodule : cps_config_port_checker
bind cps_config_port cps_config_port_checker
   #(.POR_BLOCK_CYCLES(POR_BLOCK_CYCLES)) i_chk (.clk_sys, .rst, .ce,
   .host_bus_reset_n, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rd_hit,
   .config_mode, .ld_active, .power_mgmt, .osc_ctrl);
`default_nettype wire

// [verif/cps_host_model.sv]
// Host bus controller model issuing one-cycle configuration I/O cycles.
// Assumes the block takes a strobe at the rising edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module cps_host_model
(
   // Clock.
   input wire logic clk_sys,
   // I/O cycles.
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata,
   input wire logic io_rd_hit
);
   initial
   begin
      io_addr = 16'hFFFF;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'hFF;
   end
   // Idle address and data show the inverse so no stale value lingers.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(posedge clk_sys);
      #1;
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [8:0] r);
      @(posedge clk_sys);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge clk_sys);
      #1;
      r = {io_rd_hit, io_rdata};
      io_rd = 1'b0;
      io_addr = ~a;
   endtask : rd
endmodule : cps_host_model
`default_nettype wire

// [verif/cps_config_port_tb.sv]
// Testbench for the configuration port state machine.
// Assumes the host model and checker files are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module cps_config_port_tb;
   logic clk_sys, rst, ce, host_bus_reset_n, addr_strap, io_wr, io_rd;
   logic io_rd_hit, config_mode;
   logic [15:0] io_addr, ld_active;
   logic [7:0] io_wdata, io_rdata, power_ctrl, power_mgmt, osc_ctrl;
   logic [8:0] r;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   cps_config_port #(.POR_BLOCK_CYCLES(4)) i_dut (.clk_sys, .rst, .ce,
      .host_bus_reset_n, .addr_strap, .io_addr, .io_wr, .io_rd, .io_wdata,
      .io_rdata, .io_rd_hit, .config_mode, .ld_active, .power_ctrl,
      .power_mgmt, .osc_ctrl);
   cps_host_model i_host (.clk_sys, .io_addr, .io_wr, .io_rd, .io_wdata,
      .io_rdata, .io_rd_hit);
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         final_report;
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus_reset(input logic strap);
      @(posedge clk_sys);
      #1;
      addr_strap = strap;
      host_bus_reset_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      host_bus_reset_n = 1'b1;
   endtask : bus_reset
   task automatic t_power_on;
      chk(config_mode, 1'b0);
      chk(ld_active, 16'h0000);
      chk(osc_ctrl, 8'h44);
      i_host.wr(16'h002E, 8'h55);
      chk(config_mode, 1'b0);
      repeat (6) @(posedge clk_sys);
   endtask : t_power_on
   task automatic t_run_ignore;
      i_host.wr(16'h002E, 8'hAA);
      i_host.wr(16'h002E, 8'h07);
      i_host.wr(16'h002F, 8'h01);
      chk(config_mode, 1'b0);
      i_host.rd(16'h002F, r);
      chk(r, 9'h000);
      i_host.wr(16'h004E, 8'h55);
      chk(config_mode, 1'b0);
   endtask : t_run_ignore
   task automatic t_walk;
      i_host.wr(16'h002E, 8'h55);
      chk(config_mode, 1'b1);
      i_host.wr(16'h002E, 8'h07);
      i_host.wr(16'h002F, 8'h03);
      i_host.wr(16'h002E, 8'h30);
      i_host.wr(16'h002F, 8'h01);
      chk(ld_active, 16'h0008);
      i_host.rd(16'h002F, r);
      chk(r, 9'h101);
      i_host.rd(16'h002F, r);
      chk(r, 9'h101);
      i_host.rd(16'h002E, r);
      chk(r, 9'h130);
      i_host.wr(16'h002E, 8'h22);
      i_host.wr(16'h002F, 8'h5A);
      chk(power_ctrl, 8'h5A);
      i_host.wr(16'h002E, 8'h23);
      i_host.wr(16'h002F, 8'h3C);
      chk(power_mgmt, 8'h3C);
      i_host.wr(16'h002E, 8'h02);
      i_host.wr(16'h002F, 8'h01);
      chk(ld_active, 16'h0000);
      chk(power_ctrl, 8'h00);
      chk(power_mgmt, 8'h3C);
      i_host.wr(16'h002E, 8'h07);
      i_host.wr(16'h002F, 8'h10);
      i_host.wr(16'h002E, 8'h30);
      i_host.wr(16'h002F, 8'h01);
      chk(ld_active, 16'h0000);
      i_host.rd(16'h002F, r);
      chk(r, 9'h100);
      i_host.wr(16'h002E, 8'hAA);
      chk(config_mode, 1'b0);
   endtask : t_walk
   task automatic t_strap_reloc;
      bus_reset(1'b1);
      i_host.wr(16'h002E, 8'h55);
      chk(config_mode, 1'b0);
      i_host.wr(16'h004E, 8'h55);
      chk(config_mode, 1'b1);
      i_host.wr(16'h004E, 8'h26);
      i_host.wr(16'h004F, 8'h80);
      i_host.wr(16'h0080, 8'h27);
      i_host.wr(16'h0081, 8'h01);
      i_host.rd(16'h0181, r);
      chk(r, 9'h101);
      bus_reset(1'b0);
      chk(config_mode, 1'b0);
      i_host.wr(16'h002E, 8'h55);
      chk(config_mode, 1'b1);
      i_host.wr(16'h002E, 8'hAA);
   endtask : t_strap_reloc
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      host_bus_reset_n = 1'b1;
      addr_strap = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      t_power_on;
      t_run_ignore;
      t_walk;
      t_strap_reloc;
      final_report;
   end
endmodule : cps_config_port_tb
`default_nettype wire
